// *** bench/apdm_duty_mapper_test.sv ***
// self-checking bench for the audio pcm pwm duty mapper
module apdm_duty_mapper_test;
  timeunit 1ns;
  timeprecision 1ps;
  import apdm_pkg::*;
  typedef struct packed {
    apdm_map_mode_t mode;
    logic [15:0] sample;
    logic [7:0] exp_one;
    logic [7:0] exp_two;
  } apdm_row_t;
  logic clock_in, sys_rst_in, clk_en_in, counter_run_enable_in;
  apdm_map_mode_t map_mode_in;
  logic [15:0] pcm_sample_in;
  logic pcm_valid_in, pcm_ready_out, audio_out_one_out, audio_out_two_out;
  logic period_match_flag_out;
  logic [7:0] period_count_out, held;
  logic [8:0] high_one, high_two;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int gap, n;
  apdm_row_t rows [10] = '{
    '{APDM_MAP_DIFFERENTIAL, 16'h_0000, 8'h_00, 8'h_ff},
    '{APDM_MAP_DIFFERENTIAL, 16'h_4000, 8'h_40, 8'h_bf},
    '{APDM_MAP_DIFFERENTIAL, 16'h_c000, 8'h_c0, 8'h_3f},
    '{APDM_MAP_DIFFERENTIAL, 16'h_ffff, 8'h_ff, 8'h_00},
    '{APDM_MAP_SINGLE, 16'h_0000, 8'h_00, 8'h_ff},
    '{APDM_MAP_SINGLE, 16'h_4000, 8'h_00, 8'h_7f},
    '{APDM_MAP_SINGLE, 16'h_7f80, 8'h_00, 8'h_00},
    '{APDM_MAP_SINGLE, 16'h_8000, 8'h_00, 8'h_00},
    '{APDM_MAP_SINGLE, 16'h_c000, 8'h_80, 8'h_00},
    '{APDM_MAP_SINGLE, 16'h_ffff, 8'h_ff, 8'h_00}
  };
  apdm_duty_mapper uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .counter_run_enable_in(counter_run_enable_in), .map_mode_in(map_mode_in),
    .pcm_sample_in(pcm_sample_in), .pcm_valid_in(pcm_valid_in), .pcm_ready_out(pcm_ready_out),
    .audio_out_one_out(audio_out_one_out), .audio_out_two_out(audio_out_two_out),
    .period_match_flag_out(period_match_flag_out), .period_count_out(period_count_out));
  apdm_speaker_model spk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .audio_out_one_in(audio_out_one_out), .audio_out_two_in(audio_out_two_out),
    .period_count_in(period_count_out), .high_one_out(high_one), .high_two_out(high_two));
  // ----------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------
  always #10 clock_in = ~clock_in;
  // the whole run needs about 17000 cycles; over twice that means a hang
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [8:0] expv, input logic [8:0] got);
    n_checks++;
    if (got !== expv) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, expv, got);
    end
  endtask
  // flag is a one-cycle pulse, so it is looked for at every falling edge
  task automatic wait_flag(output int k);
    k = 0;
    do begin
      @(negedge clock_in);
      k++;
    end while (period_match_flag_out !== 1'b1 && k < 600);
    check("flag_seen", 9'h_001, {8'h_00, period_match_flag_out});
  endtask
  task automatic push(input apdm_map_mode_t m, input logic [15:0] s);
    map_mode_in = m;
    pcm_sample_in = s;
    pcm_valid_in = 1'b1;
    @(negedge clock_in);
    pcm_valid_in = 1'b0;
    // one edge with valid low, so back-to-back calls never touch it twice at once
    @(negedge clock_in);
  endtask
  task automatic reset_dut();
    sys_rst_in = 1'b1;
    counter_run_enable_in = 1'b0;
    repeat (3) @(negedge clock_in);
    sys_rst_in = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    clk_en_in = 1'b1;
    map_mode_in = APDM_MAP_DIFFERENTIAL;
    pcm_sample_in = 16'h_0000;
    pcm_valid_in = 1'b0;
    reset_dut();
    repeat (10) @(negedge clock_in);
    check("count_idle", 9'h_000, {1'b0, period_count_out});
    check("out_one_idle", 9'h_000, {8'h_00, audio_out_one_out});
    counter_run_enable_in = 1'b1;
    foreach (rows[i]) begin
      push(rows[i].mode, rows[i].sample);
      wait_flag(gap);
      wait_flag(gap);
      wait_flag(gap);
      check("period", 9'h_100, gap[8:0]);
      check("high_one", {1'b0, rows[i].exp_one}, high_one);
      check("high_two", {1'b0, rows[i].exp_two}, high_two);
    end
    // fill while stopped: fifo plus pending slot, then refusal
    reset_dut();
    check("count_reset", 9'h_000, {1'b0, period_count_out});
    check("out_one_reset", 9'h_000, {8'h_00, audio_out_one_out});
    check("flag_reset", 9'h_000, {8'h_00, period_match_flag_out});
    check("ready_reset", 9'h_001, {8'h_00, pcm_ready_out});
    n = 0;
    while (pcm_ready_out === 1'b1 && n < 40) begin
      push(APDM_MAP_DIFFERENTIAL, 16'h_8000);
      n++;
    end
    check("accepted", 9'h_021, n[8:0]);
    held = period_count_out;
    counter_run_enable_in = 1'b1;
    clk_en_in = 1'b0;
    repeat (20) @(negedge clock_in);
    check("count_frozen", {1'b0, held}, {1'b0, period_count_out});
    clk_en_in = 1'b1;
    // first period after a load must already use the new pair at count zero
    wait_flag(gap);
    wait_flag(gap);
    check("high_one_first", 9'h_080, high_one);
    repeat (33) begin
      wait_flag(gap);
    end
    check("ready_drained", 9'h_001, {8'h_00, pcm_ready_out});
    check("high_one_drain", 9'h_080, high_one);
    check("high_two_drain", 9'h_07f, high_two);
    @(negedge clock_in);
    counter_run_enable_in = 1'b0;
    repeat (3) @(negedge clock_in);
    held = period_count_out;
    repeat (5) @(negedge clock_in);
    check("count_held", {1'b0, held}, {1'b0, period_count_out});
    check("out_one_off", 9'h_000, {8'h_00, audio_out_one_out});
    complete_run();
  end
endmodule // apdm_duty_mapper_test

// *** bench/apdm_speaker_model.sv ***
// speaker driver model: counts high clocks of each pwm pin over one period
module apdm_speaker_model (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic audio_out_one_in,
  input wire logic audio_out_two_in,
  input wire logic [apdm_pkg::APDM_DUTY_W-1:0] period_count_in,
  output logic [8:0] high_one_out,
  output logic [8:0] high_two_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import apdm_pkg::*;
  logic [8:0] acc_one_q;
  logic [8:0] acc_two_q;
  // ----------------------------------------
  // integrator, closed on the last count of a period
  // ----------------------------------------
  // a real driver low-passes the pins; an exact high count is stricter
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      acc_one_q <= 9'h_000;
      acc_two_q <= 9'h_000;
      high_one_out <= 9'h_000;
      high_two_out <= 9'h_000;
    end else if (period_count_in == APDM_PERIOD_COMPARE) begin
      high_one_out <= acc_one_q + 9'(audio_out_one_in);
      high_two_out <= acc_two_q + 9'(audio_out_two_in);
      acc_one_q <= 9'h_000;
      acc_two_q <= 9'h_000;
    end else begin
      acc_one_q <= acc_one_q + 9'(audio_out_one_in);
      acc_two_q <= acc_two_q + 9'(audio_out_two_in);
    end
  end
endmodule // apdm_speaker_model

// *** design/apdm_duty_mapper.sv ***
// top of the audio pcm pwm duty mapper: fifo, mapping, shadows, pwm pair
module apdm_duty_mapper
  import apdm_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic counter_run_enable_in,
  input wire apdm_pkg::apdm_map_mode_t map_mode_in,
  input wire logic [apdm_pkg::APDM_SAMPLE_W-1:0] pcm_sample_in,
  input wire logic pcm_valid_in,
  output logic pcm_ready_out,
  output logic audio_out_one_out,
  output logic audio_out_two_out,
  output logic period_match_flag_out,
  output logic [apdm_pkg::APDM_DUTY_W-1:0] period_count_out
);
  import apdm_pkg::*;

  logic [APDM_SAMPLE_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready_in;
  wire logic fifo_take;
  wire logic [APDM_SAMPLE_W-1:0] pcm_sample_inverted;
  wire apdm_duty_pair_t map_diff;
  wire apdm_duty_pair_t map_single;
  wire apdm_duty_pair_t map_sel;
  wire logic overflow;
  apdm_duty_pair_t pend_q;
  logic pend_valid_q;
  apdm_duty_pair_t active_q;
  wire apdm_duty_pair_t active_d;
  logic [APDM_DUTY_W-1:0] count_q;
  logic [APDM_DUTY_W-1:0] count_d;
  logic out_one_q;
  logic out_two_q;
  logic flag_q;

  // ------------------------------------------------------------
  // sample buffer
  // ------------------------------------------------------------
  // one sample per period is drained, so the fifo really fills and stalls
  apdm_fifo #(
    .WIDTH(APDM_SAMPLE_W),
    .DEPTH(APDM_FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .wr_data_in(pcm_sample_in),
    .wr_valid_in(pcm_valid_in),
    .wr_ready_out(pcm_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_ready_in)
  );

  // ------------------------------------------------------------
  // sample to compare mapping
  // ------------------------------------------------------------
  // the pending slot accepts a new pair whenever it is empty
  assign fifo_ready_in = !pend_valid_q || overflow;
  assign fifo_take = fifo_valid && fifo_ready_in && clk_en_in;
  assign pcm_sample_inverted = ~fifo_data;
  assign map_diff.duty_one_compare = fifo_data[APDM_DIFF_MSB:APDM_DIFF_LSB];
  assign map_diff.duty_two_compare =
      pcm_sample_inverted[APDM_DIFF_MSB:APDM_DIFF_LSB];
  assign map_single.duty_one_compare = fifo_data[APDM_SIGN_BIT] ?
      fifo_data[APDM_SINGLE_MSB:APDM_SINGLE_LSB] : APDM_DUTY_RESET;
  assign map_single.duty_two_compare = fifo_data[APDM_SIGN_BIT] ?
      APDM_DUTY_RESET : pcm_sample_inverted[APDM_SINGLE_MSB:APDM_SINGLE_LSB];
  assign map_sel = (map_mode_in == APDM_MAP_SINGLE) ? map_single : map_diff;

  // ------------------------------------------------------------
  // period counter
  // ------------------------------------------------------------
  // counter holds still until run enable; controller sets it last
  assign overflow = counter_run_enable_in && (count_q == APDM_PERIOD_COMPARE);
  always_comb begin
    count_d = count_q;
    if (overflow) begin
      count_d = APDM_COUNT_RESET;
    end else if (counter_run_enable_in) begin
      count_d = count_q + 8'h_0001;
    end
  end

  // pending shadow pair, one slot deep; fifo holds the backlog
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pend_q <= '0;
      pend_valid_q <= 1'b0;
    end else if (clk_en_in) begin
      if (fifo_take) begin
        pend_q <= map_sel;
        pend_valid_q <= 1'b1;
      end else if (overflow) begin
        pend_valid_q <= 1'b0;
      end
    end
  end

  // next active pair: the pending pair replaces it only at the overflow edge
  assign active_d = (overflow && pend_valid_q) ? pend_q : active_q;

  // active compares change only at overflow so no period is torn
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      active_q <= '0;
    end else if (clk_en_in) begin
      active_q <= active_d;
    end
  end

  // counter and registered outputs; count zero already sees the new pair
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      count_q <= APDM_COUNT_RESET;
      out_one_q <= 1'b0;
      out_two_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (clk_en_in) begin
      count_q <= count_d;
      out_one_q <= counter_run_enable_in &&
          (count_d < active_d.duty_one_compare);
      out_two_q <= counter_run_enable_in &&
          (count_d < active_d.duty_two_compare);
      flag_q <= overflow;
    end
  end

  assign audio_out_one_out = out_one_q;
  assign audio_out_two_out = out_two_q;
  assign period_match_flag_out = flag_q;
  assign period_count_out = count_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // mapping is checked where it lands, in the pending shadow pair
  property p_diff_map;
    @(posedge clock_in) disable iff (sys_rst_in)
      (fifo_take && map_mode_in == APDM_MAP_DIFFERENTIAL) |=>
        (pend_q.duty_two_compare == ~$past(fifo_data[APDM_DIFF_MSB:APDM_DIFF_LSB])) &&
        (pend_q.duty_one_compare == $past(fifo_data[APDM_DIFF_MSB:APDM_DIFF_LSB]));
  endproperty
  a_diff_map: assert property (p_diff_map) else $error("diff map wrong");

  property p_single_neg;
    @(posedge clock_in) disable iff (sys_rst_in)
      (fifo_take && map_mode_in == APDM_MAP_SINGLE && !fifo_data[APDM_SIGN_BIT]) |=>
        (pend_q.duty_one_compare == APDM_DUTY_RESET) &&
        (pend_q.duty_two_compare == ~$past(fifo_data[APDM_SINGLE_MSB:APDM_SINGLE_LSB]));
  endproperty
  a_single_neg: assert property (p_single_neg) else $error("single low map");

  property p_single_pos;
    @(posedge clock_in) disable iff (sys_rst_in)
      (fifo_take && map_mode_in == APDM_MAP_SINGLE && fifo_data[APDM_SIGN_BIT]) |=>
        (pend_q.duty_one_compare == $past(fifo_data[APDM_SINGLE_MSB:APDM_SINGLE_LSB])) &&
        (pend_q.duty_two_compare == APDM_DUTY_RESET);
  endproperty
  a_single_pos: assert property (p_single_pos) else $error("single high map");

  property p_hold_stopped;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && !counter_run_enable_in) |=> $stable(count_q) && !out_one_q;
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("ran while off");

  property p_shadow_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
      !(clk_en_in && overflow) |=> $stable(active_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow leaked");

  property p_flag_wrap;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && counter_run_enable_in && count_q == 8'h_00ff) |=>
        flag_q && count_q == 8'h_0000;
  endproperty
  a_flag_wrap: assert property (p_flag_wrap) else $error("no wrap at 255");

  property p_zero_low;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && active_d.duty_two_compare == 8'h_0000) |=> !out_two_q;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty not low");

  property p_duty_edge;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && counter_run_enable_in && !overflow && $stable(active_q)
        && count_d == active_q.duty_one_compare) |=> !out_one_q;
  endproperty
  a_duty_edge: assert property (p_duty_edge) else $error("duty edge late");

  property p_flag_pulse;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && flag_q) |=> !flag_q;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag held");

  property p_load_at_wrap;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && overflow && pend_valid_q) |=> (active_q == $past(pend_q));
  endproperty
  a_load_at_wrap: assert property (p_load_at_wrap) else $error("shadow not loaded");

  // an output may only be high below the compare that owns this period
  property p_out_align;
    @(posedge clock_in) disable iff (sys_rst_in)
      (out_one_q || out_two_q) |->
        (!out_one_q || count_q < active_q.duty_one_compare) &&
        (!out_two_q || count_q < active_q.duty_two_compare);
  endproperty
  a_out_align: assert property (p_out_align) else $error("output past compare");

  property p_count_step;
    @(posedge clock_in) disable iff (sys_rst_in)
      (clk_en_in && counter_run_enable_in && !overflow) |=>
        (count_q == $past(count_q) + 8'h_0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");
endmodule // apdm_duty_mapper

// *** design/apdm_fifo.sv ***
// sample fifo with parameterised width and depth, valid/ready both sides
module apdm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic wr_ready_q;
  wire logic [AW:0] count_d;
  wire logic do_wr;
  wire logic do_rd;

  // ------------------------------------------------------------
  // handshake decode
  // ------------------------------------------------------------
  // ready is a flop fed from the next fill count, so it never lags a write
  assign wr_ready_out = wr_ready_q;
  assign count_d = count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  assign rd_valid_out = (count_q != '0);
  assign do_wr = wr_valid_in && wr_ready_out && clk_en_in;
  assign do_rd = rd_valid_out && rd_ready_in && clk_en_in;
  assign rd_data_out = mem_q[rd_ptr_q];

  // storage array, no reset needed on data
  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  // pointers and fill count; wrap relies on power-of-two depth
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      wr_ready_q <= 1'b1;
    end else begin
      if (do_wr) wr_ptr_q <= wr_ptr_q + AW'(1);
      if (do_rd) rd_ptr_q <= rd_ptr_q + AW'(1);
      count_q <= count_d;
      wr_ready_q <= (count_d != (AW+1)'(DEPTH));
    end
  end
endmodule // apdm_fifo

// *** inc/apdm_pkg.sv ***
// package of constants and types for the audio pcm pwm duty mapper
package apdm_pkg;
  // ------------------------------------------------------------
  // widths and sizes
  // ------------------------------------------------------------
  localparam int APDM_SAMPLE_W = 16;
  localparam int APDM_DUTY_W = 8;
  localparam int APDM_FIFO_DEPTH = 32;
  // period of 256 timer clocks, counter wraps at period_compare
  localparam logic [7:0] APDM_PERIOD_COMPARE = 8'h_00ff;
  localparam logic [7:0] APDM_COUNT_RESET = 8'h_0000;
  localparam logic [7:0] APDM_DUTY_RESET = 8'h_0000;
  // differential mapping takes bits 15:8, single mapping bits 14:7
  localparam int APDM_DIFF_MSB = 15;
  localparam int APDM_DIFF_LSB = 8;
  localparam int APDM_SINGLE_MSB = 14;
  localparam int APDM_SINGLE_LSB = 7;
  localparam int APDM_SIGN_BIT = 15;

  typedef enum logic {
    APDM_MAP_DIFFERENTIAL,
    APDM_MAP_SINGLE
  } apdm_map_mode_t;

  // pair of compare values that travel together into shadow storage
  typedef struct packed {
    logic [APDM_DUTY_W-1:0] duty_one_compare;
    logic [APDM_DUTY_W-1:0] duty_two_compare;
  } apdm_duty_pair_t;
endpackage
